// >>> rtl/bdc_buffer_dma.sv
// two-channel buffer dma: firmware register port, buffer ram port,
// sequencer byte streams on channel 0, micro byte port on channel 1
// assumes ram answers each request with one mem_ack_in pulse
`timescale 1ns/1ps
`default_nettype none
module bdc_buffer_dma
    import bdc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    // firmware register port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    // buffer ram port
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic      [15:0] mem_addr_out,
    output logic      [7:0]  mem_wdata_out,
    input  wire logic        mem_ack_in,
    input  wire logic [7:0]  mem_rdata_in,
    // sequencer to ram stream
    input  wire logic        seq_wvalid_in,
    input  wire logic [7:0]  seq_wdata_in,
    output logic             seq_wready_out,
    // ram to sequencer stream
    output logic             seq_rvalid_out,
    output logic      [7:0]  seq_rdata_out,
    input  wire logic        seq_rready_in,
    // status
    output logic             int_mem_out,
    output logic      [1:0]  chan_en_out
);
    // register decode shared by both channels
    function automatic logic chan_hit(input logic [7:0] a, input int ch,
                                      input logic [7:0] ofs);
        return a == 8'(ofs + CH_STRIDE * 8'(ch));
    endfunction

    bdc_state_e               state_q;
    logic                     act_q;
    logic [15:0]              mem_addr_q;
    logic                     mem_we_q;
    logic [7:0]               mem_wdata_q;
    logic [7:0]               rdata_q;
    logic [7:0]               mwr_data_q;
    logic                     mwr_pend_q;
    logic [7:0]               mrd_data_q;
    logic                     mrd_val_q;
    logic [NUM_CH-1:0][15:0]  addr_w;
    logic [NUM_CH-1:0][15:0]  cnt_w;
    logic [NUM_CH-1:0][15:0]  rld_w;
    logic [NUM_CH-1:0][7:0]   ctrl_w;
    logic [NUM_CH-1:0]        irq_w;
    logic [NUM_CH-1:0]        done;
    logic [NUM_CH-1:0]        abort;
    logic [NUM_CH-1:0]        want;
    logic [NUM_CH-1:0]        src_ok;
    logic                     fifo_in_ready;

    // strobes qualified by the clock enable
    wire wr      = ce_in & reg_wr_in;
    wire rd      = ce_in & reg_rd_in;
    wire cyc     = (state_q == ST_CYCLE);
    wire stat_rd = rd & (reg_addr_in == OFS_STATUS);
    wire port_rd = rd & (reg_addr_in == OFS_MICRO_PORT);
    wire port_wr = wr & (reg_addr_in == OFS_MICRO_PORT);

    // per-channel registers and counters
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : gen_ch
            logic [15:0] addr_q;
            logic [15:0] cnt_q;
            logic [15:0] rld_q;
            logic [7:0]  ctrl_q;
            logic        irq_q;
            wire ctl_wr = wr & (reg_addr_in == 8'(OFS_CTRL0 + 8'(c))); // [RL5]
            wire a_lo   = wr & chan_hit(reg_addr_in, c, OFS_ADDR_LO);   // [RL5]
            wire a_hi   = wr & chan_hit(reg_addr_in, c, OFS_ADDR_HI);
            wire c_lo   = wr & chan_hit(reg_addr_in, c, OFS_CNT_LO);
            wire c_hi   = wr & chan_hit(reg_addr_in, c, OFS_CNT_HI);
            wire last   = done[c] & (cnt_q == ONE16);
            // auto-disable is the falling of enable that raises the irq
            wire fall   = last & ~ctrl_q[CTL_ALWAYS];        // [RL10] [RL13]
            wire [15:0] addr_n = addr_q + ONE16;             // [RL1] [RL2]
            wire [15:0] cnt_n  = cnt_q - ONE16;              // [RL3] [RL4]

            assign addr_w[c] = addr_q;
            assign cnt_w[c]  = cnt_q;
            assign rld_w[c]  = rld_q;
            assign ctrl_w[c] = ctrl_q;
            assign irq_w[c]  = irq_q;
            assign abort[c]  = ctl_wr & ~reg_wdata_in[CTL_EN]; // [RL6]
            assign done[c]   = cyc & mem_ack_in & ce_in & (act_q == c)
                               & ~abort[c];
            // [RL14] only enabled channels with work left may ask
            // an abort in the same cycle must also block a new issue
            assign want[c]   = ctrl_q[CTL_EN] & (cnt_q != WORD_RST) & src_ok[c]
                               & ~abort[c];              // [RL6] [RL14]

            // address: firmware byte writes win over the step
            always_ff @(posedge mclk_in)
            begin
                if (srst_in)
                    addr_q <= WORD_RST;
                else if (a_lo)
                    addr_q <= {addr_q[15:8], reg_wdata_in};
                else if (a_hi)
                    addr_q <= {reg_wdata_in, addr_q[7:0]};
                else if (done[c])
                    addr_q <= addr_n;                        // [RL1] [RL2]
            end

            // count and its reload copy taken from firmware writes
            always_ff @(posedge mclk_in)
            begin
                if (srst_in)
                begin
                    cnt_q <= WORD_RST;
                    rld_q <= WORD_RST;
                end
                else if (c_lo | c_hi)
                begin
                    cnt_q <= c_lo ? {cnt_q[15:8], reg_wdata_in}
                                  : {reg_wdata_in, cnt_q[7:0]};
                    rld_q <= c_lo ? {rld_q[15:8], reg_wdata_in}
                                  : {reg_wdata_in, rld_q[7:0]};
                end
                else if (last & ctrl_q[CTL_RELOAD])
                    cnt_q <= rld_q;                          // [RL8] [RL9]
                else if (done[c])
                    cnt_q <= cnt_n;                          // [RL3] [RL4]
            end

            // control byte; a firmware write wins over auto-disable
            always_ff @(posedge mclk_in)
            begin
                if (srst_in)
                    ctrl_q <= CTRL_RST;
                else if (ctl_wr)
                    ctrl_q <= reg_wdata_in;                  // [RL6] [RL7]
                else if (fall)
                    ctrl_q[CTL_EN] <= 1'b0;                  // [RL10]
            end

            // sticky cause flag; setting wins over the status read clear
            always_ff @(posedge mclk_in)
            begin
                if (srst_in)
                    irq_q <= 1'b0;
                else if (fall & ctrl_q[CTL_IE])
                    irq_q <= 1'b1;                           // [RL12] [RL13]
                else if (stat_rd)
                    irq_q <= 1'b0;
            end
        end
    endgenerate

    // source or sink readiness per channel, by direction
    assign src_ok[0] = ctrl_w[0][CTL_DIR] ? seq_wvalid_in : fifo_in_ready;
    assign src_ok[1] = ctrl_w[1][CTL_DIR] ? mwr_pend_q : ~mrd_val_q;

    // fixed priority: channel 0 first, the sequencer cannot wait long
    wire idle   = (state_q == ST_IDLE) & ce_in;
    wire g0     = idle & want[0];
    wire g1     = idle & want[1] & ~want[0];
    wire issue  = g0 | g1;
    wire gch    = g1;
    wire [7:0] issue_data = gch ? mwr_data_q : seq_wdata_in;
    wire ab_act = cyc & abort[act_q];

    assign seq_wready_out = g0 & ctrl_w[0][CTL_DIR];         // [RL7]

    // memory cycle sequencer
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
            state_q <= ST_IDLE;
        else if (ce_in)
            case (state_q)
                ST_IDLE:  state_q <= issue ? ST_CYCLE : ST_IDLE;
                ST_CYCLE: state_q <= (mem_ack_in | ab_act) ? ST_IDLE
                                                           : ST_CYCLE; // [RL6]
                default:  state_q <= ST_IDLE;
            endcase
    end

    // cycle address, direction and write data captured at issue
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            act_q       <= 1'b0;
            mem_addr_q  <= WORD_RST;
            mem_we_q    <= 1'b0;
            mem_wdata_q <= BYTE_RST;
        end
        else if (issue)
        begin
            act_q       <= gch;
            mem_addr_q  <= addr_w[gch];
            mem_we_q    <= ctrl_w[gch][CTL_DIR];             // [RL7]
            mem_wdata_q <= issue_data;
        end
    end

    assign mem_req_out   = cyc;
    assign mem_we_out    = mem_we_q;
    assign mem_addr_out  = mem_addr_q;
    assign mem_wdata_out = mem_wdata_q;

    // micro byte port: write holds a byte for ram, read holds one from ram
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            mwr_data_q <= BYTE_RST;
            mwr_pend_q <= 1'b0;
            mrd_data_q <= BYTE_RST;
            mrd_val_q  <= 1'b0;
        end
        else
        begin
            if (port_wr)
                mwr_data_q <= reg_wdata_in;
            if (port_wr)
                mwr_pend_q <= 1'b1;
            else if (g1 & ctrl_w[1][CTL_DIR])
                mwr_pend_q <= 1'b0;
            if (done[1] & ~mem_we_q)
            begin
                mrd_data_q <= mem_rdata_in;
                mrd_val_q  <= 1'b1;
            end
            else if (port_rd)
                mrd_val_q  <= 1'b0;
        end
    end

    // ram bytes for the sequencer pass a two-entry buffer; room is
    // checked at issue so the single outstanding byte always fits
    bdc_buf2 u_rbuf
    (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .ce_in         (ce_in),
        .in_valid_in   (done[0] & ~mem_we_q),
        .in_data_in    (mem_rdata_in),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (seq_rvalid_out),
        .out_data_out  (seq_rdata_out),
        .out_ready_in  (seq_rready_in)
    );

    // read-back selection
    wire [7:0] status_w = {2'h0, mwr_pend_q, mrd_val_q, irq_w,
                           ctrl_w[1][CTL_EN], ctrl_w[0][CTL_EN]};
    wire [7:0] rd_mux =
        (reg_addr_in == OFS_STATUS)     ? status_w :
        chan_hit(reg_addr_in, 0, OFS_CNT_LO) ? cnt_w[0][7:0] :
        chan_hit(reg_addr_in, 0, OFS_CNT_HI) ? cnt_w[0][15:8] :
        chan_hit(reg_addr_in, 1, OFS_CNT_LO) ? cnt_w[1][7:0] :
        chan_hit(reg_addr_in, 1, OFS_CNT_HI) ? cnt_w[1][15:8] :
        (reg_addr_in == OFS_MICRO_PORT) ? mrd_data_q : BYTE_RST;

    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
            rdata_q <= BYTE_RST;
        else if (rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata_out = rdata_q;
    assign int_mem_out   = |irq_w;
    assign chan_en_out   = {ctrl_w[1][CTL_EN], ctrl_w[0][CTL_EN]};

    // checks on channel 0 bookkeeping and the cycle gate
    sequence s_ch0_step;
        done[0] && !reg_wr_in;
    endsequence
    sequence s_ch0_last;
        s_ch0_step ##0 cnt_w[0] == ONE16;
    endsequence

    chk_addr_step: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL1] [RL2]
        s_ch0_step |=> addr_w[0] == $past(addr_w[0]) + ONE16)
        else $error("address did not step after a byte");
    chk_count_step: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL3] [RL4]
        s_ch0_step ##0 cnt_w[0] != ONE16
        |=> cnt_w[0] == $past(cnt_w[0]) - ONE16)
        else $error("count did not step down after a byte");
    chk_reload_count: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL8]
        s_ch0_last ##0 ctrl_w[0][CTL_RELOAD] |=> cnt_w[0] == $past(rld_w[0]))
        else $error("count not reloaded at zero");
    chk_auto_off: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL10]
        s_ch0_last ##0 !ctrl_w[0][CTL_ALWAYS] |=> !chan_en_out[0])
        else $error("channel still enabled at zero count");
    chk_stay_on: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL11]
        s_ch0_last ##0 ctrl_w[0][CTL_ALWAYS] |=> chan_en_out[0] && !irq_w[0])
        else $error("always-enabled channel dropped");
    chk_irq_raise: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL12] [RL13]
        s_ch0_last ##0 !ctrl_w[0][CTL_ALWAYS] && ctrl_w[0][CTL_IE]
        |=> irq_w[0] && int_mem_out)
        else $error("no memory interrupt at end of block");
    chk_abort_stop: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL6]
        abort[0] |=> !chan_en_out[0] && !(mem_req_out && act_q == 1'b0))
        else $error("abort left channel 0 running");
    chk_issue_gate: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL14]
        $rose(mem_req_out) |-> (act_q
            ? $past(ctrl_w[1][CTL_EN]) && $past(cnt_w[1]) != WORD_RST
            : $past(ctrl_w[0][CTL_EN]) && $past(cnt_w[0]) != WORD_RST))
        else $error("memory cycle without enable or count");
    chk_dir_we: assert property (@(posedge mclk_in) disable iff (srst_in) // [RL7]
        g0 |=> mem_req_out && mem_we_out == $past(ctrl_w[0][CTL_DIR]))
        else $error("write strobe does not follow direction");
endmodule
`default_nettype wire

// >>> inc/bdc_pkg.sv
// constants, field positions and states of the two-channel buffer dma block
// assumes one byte-wide register port and one byte-wide buffer ram port
// Behaviour
// RL1: low address byte is written by firmware and steps after every byte moved
// RL2: high address byte steps on low byte overflow, forming one 16-bit address
// RL3: low count byte is written by firmware and steps down after each transfer
// RL4: high count byte steps down on low byte underflow, one 16-bit counter
// RL5: two independent channels, each at its own register locations
// RL6: enable bit one enables; zero aborts any transfer at once and disables
// RL7: direction clear moves ram to peripheral; set moves peripheral to ram
// RL8: reload set restores the pre-transfer count when the count reaches zero
// RL9: firmware sets enable and always-enabled with reload for back-to-back records
// RL10: always-enabled clear disables the channel when its count reaches zero
// RL11: always-enabled set keeps the channel enabled after the count reaches zero
// RL12: interrupt enable set raises the memory interrupt at end of block
// RL13: interrupt comes from enable falling; always-enabled channels never raise it
// RL14: memory cycles only while enabled with nonzero count, stop at zero
package bdc_pkg;
    localparam int NUM_CH = 2;

    // register offsets on the firmware port
    localparam logic [7:0] OFS_ADDR_LO    = 8'h00;
    localparam logic [7:0] OFS_ADDR_HI    = 8'h01;
    localparam logic [7:0] OFS_CNT_LO     = 8'h02;
    localparam logic [7:0] OFS_CNT_HI     = 8'h03;
    localparam logic [7:0] CH_STRIDE      = 8'h04;
    localparam logic [7:0] OFS_CTRL0      = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_MICRO_PORT = 8'h18;

    // control byte fields
    localparam int CTL_EN     = 0;
    localparam int CTL_DIR    = 1;
    localparam int CTL_RELOAD = 2;
    localparam int CTL_IE     = 3;
    localparam int CTL_ALWAYS = 4;

    // status byte fields
    localparam int ST_EN_BASE  = 0;
    localparam int ST_IRQ_BASE = 2;
    localparam int ST_MRD_VAL  = 4;
    localparam int ST_MWR_PEND = 5;

    // reset values and counter steps
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] ONE16    = 16'h0001;

    typedef enum {ST_IDLE, ST_CYCLE} bdc_state_e;
endpackage

// >>> rtl/bdc_buf2.sv
// two-entry buffer between the ram read path and the sequencer
// assumes one clock; ce_in low freezes it
`timescale 1ns/1ps
`default_nettype none
module bdc_buf2
(
    // clock, reset, enable
    input  wire logic       mclk_in,
    input  wire logic       srst_in,
    input  wire logic       ce_in,
    // fill side
    input  wire logic       in_valid_in,
    input  wire logic [7:0] in_data_in,
    output logic            in_ready_out,
    // drain side
    output logic            out_valid_out,
    output logic [7:0]      out_data_out,
    input  wire logic       out_ready_in
);
    logic [7:0] mem_q [2];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] fill_q;
    wire        push = ce_in & in_valid_in & in_ready_out;
    wire        pop  = ce_in & out_valid_out & out_ready_in;

    // honest full and empty from the fill count
    assign in_ready_out  = (fill_q != 2'h2);
    assign out_valid_out = (fill_q != 2'h0);
    assign out_data_out  = mem_q[rp_q];

    // storage has no reset, only pointers and fill level do
    always_ff @(posedge mclk_in)
        if (push)
            mem_q[wp_q] <= in_data_in;

    // pointers and fill level
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            wp_q   <= 1'b0;
            rp_q   <= 1'b0;
            fill_q <= 2'h0;
        end
        else
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            fill_q <= 2'(fill_q + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule
`default_nettype wire

// >>> tb/bdc_ram_model.sv
// buffer ram partner: 64k bytes, one ack pulse per request
// assumes requests hold until the ack edge; latency is random, 1 to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module bdc_ram_model
(
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // ram port seen from the block
    input  wire logic        mem_req_in,
    input  wire logic        mem_we_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    output logic             mem_ack_out,
    output logic      [7:0]  mem_rdata_out
);
    logic [7:0] ram [0:65535];
    int         wait_q;

    // preload a pattern the bench can work out from the address
    initial
    begin
        for (int i = 0; i < 65536; i++)
            ram[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end

    // data toggles outside the ack cycle so a stale byte never looks valid
    always @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            mem_ack_out   <= 1'b0;
            mem_rdata_out <= 8'h00;
            wait_q        <= 1;
        end
        else if (mem_req_in && !mem_ack_out && wait_q == 0)
        begin
            mem_ack_out   <= 1'b1;
            mem_rdata_out <= ram[mem_addr_in];
            if (mem_we_in)
                ram[mem_addr_in] <= mem_wdata_in;
            wait_q        <= $urandom_range(3, 0);
        end
        else
        begin
            mem_ack_out   <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
            if (mem_req_in && !mem_ack_out)
                wait_q <= wait_q - 1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/bdc_buffer_dma_tb_top.sv
// self-checking bench for the two-channel buffer dma
// assumes the ram partner model; bench plays firmware and sequencer
`timescale 1ns/1ps
`default_nettype none
module bdc_buffer_dma_tb_top;
    import bdc_pkg::*;
    logic        mclk_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_pend = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic        mem_req_out, mem_we_out, mem_ack, int_mem_out;
    logic [15:0] mem_addr_out;
    logic [7:0]  mem_wdata_out, mem_rdata, seq_rdata_out;
    logic        seq_wvalid_in = 1'b0, seq_wready_out, seq_rvalid_out;
    logic        seq_rready_in = 1'b0;
    logic [7:0]  seq_wdata_in = 8'h00;
    logic [1:0]  chan_en_out;
    logic [23:0] exp_q[$];
    int          n_errors = 0, samples_checked = 0, cycles = 0, hits;

    bdc_buffer_dma i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_ack_in(mem_ack), .mem_rdata_in(mem_rdata),
        .seq_wvalid_in(seq_wvalid_in), .seq_wdata_in(seq_wdata_in),
        .seq_wready_out(seq_wready_out), .seq_rvalid_out(seq_rvalid_out),
        .seq_rdata_out(seq_rdata_out), .seq_rready_in(seq_rready_in),
        .int_mem_out(int_mem_out), .chan_en_out(chan_en_out));

    bdc_ram_model i_ram (.mclk_in(mclk_in), .srst_in(srst_in),
        .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
        .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
        .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));

    // 40 mhz clock and a hang guard well above the expected run length
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a result with no note pending is itself a mismatch
    task automatic take(input logic [23:0] got);
        logic [23:0] exp;
        exp = (exp_q.size() == 0) ? ~got : exp_q.pop_front();
        cmp(got, exp);
    endtask

    // watch every result as it appears and compare with the oldest note
    always @(posedge mclk_in)
    begin
        rd_pend <= reg_rd_in;
        if (rd_pend)
            take({16'h0000, reg_rdata_out});
        if (mem_req_out && mem_ack && mem_we_out)
            take({mem_addr_out, mem_wdata_out});
        if (seq_rvalid_out && seq_rready_in)
            take({16'h0000, seq_rdata_out});
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_wr_in    = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        @(negedge mclk_in);
        reg_wr_in    = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back({16'h0000, d});
        @(negedge mclk_in);
        reg_rd_in   = 1'b1;
        reg_addr_in = a;
        @(negedge mclk_in);
        reg_rd_in   = 1'b0;
    endtask

    task automatic prog(input int ch, input logic [15:0] a, input logic [15:0] n);
        logic [7:0] b;
        b = 8'(ch) * CH_STRIDE;
        wr(b + OFS_ADDR_LO, a[7:0]);
        wr(b + OFS_ADDR_HI, a[15:8]);
        wr(b + OFS_CNT_LO, n[7:0]);
        wr(b + OFS_CNT_HI, n[15:8]);
    endtask

    // sequencer bytes held until the edge that samples ready high
    task automatic seq_send(input logic [15:0] a, input int n);
        int w;
        seq_wvalid_in = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            seq_wdata_in = 8'($urandom);
            exp_q.push_back({a + 16'(i), seq_wdata_in});
            // ready is looked at once settled; the next rising edge takes it
            w = 0;
            #1;
            while (seq_wready_out !== 1'b1 && w < 200)
            begin
                @(negedge mclk_in);
                #1;
                w++;
            end
            @(negedge mclk_in);
        end
        seq_wvalid_in = 1'b0;
    endtask

    // wait for all notes to be met, then let the count bookkeeping land
    task automatic drain(input string name);
        int w;
        w = 0;
        while (exp_q.size() != 0 && w < 5000)
        begin
            @(negedge mclk_in);
            seq_rready_in = 1'($urandom);
            w++;
        end
        if (w == 5000)
            cmp(24'(exp_q.size()), 24'h00_0000);
        repeat (4) @(negedge mclk_in);
        $display("test %0s done", name);
    endtask

    initial
    begin
        void'($urandom(28616));
        repeat (5) @(negedge mclk_in);
        srst_in = 1'b0;
        // reset state: disabled, idle, zero count
        cmp({21'h0, chan_en_out, mem_req_out}, 24'h00_0000);
        rd(OFS_CNT_LO, 8'h00);
        rd(OFS_STATUS, 8'h00);
        drain("reset");
        // 258 bytes in across an address carry; count borrow, reload, irq
        prog(0, 16'h12FE, 16'h0102);
        wr(OFS_CTRL0, 8'h0F);
        seq_send(16'h12FE, 258);
        drain("write_reload");
        cmp({22'h0, chan_en_out[0], int_mem_out}, 24'h00_0001);
        rd(OFS_STATUS, 8'h04);
        rd(OFS_CNT_LO, 8'h02);
        rd(OFS_CNT_HI, 8'h01);
        drain("status_clear");
        cmp(24'(int_mem_out), 24'h00_0000);
        // ram to sequencer with a long stall, always-enabled: no irq
        prog(0, 16'h0040, 16'h0004);
        seq_rready_in = 1'b0;
        wr(OFS_CTRL0, 8'h19);
        repeat (20) @(negedge mclk_in);
        rd(OFS_CNT_LO, 8'h02);
        for (int i = 0; i < 4; i++)
            exp_q.push_back({16'h0000, 8'h40 + 8'(i) ^ 8'h5A});
        drain("read_stall");
        cmp({22'h0, chan_en_out[0], int_mem_out}, 24'h00_0002);
        hits = 0;
        repeat (10) @(negedge mclk_in) hits += int'(mem_req_out);
        cmp(24'(hits), 24'h00_0000);
        wr(OFS_CTRL0, 8'h00);
        // channel 1 from the micro write port, carry at 20ff
        prog(1, 16'h20FF, 16'h0002);
        wr(OFS_CTRL0 + 8'h01, 8'h0B);
        for (int i = 0; i < 2; i++)
        begin
            seq_wdata_in = 8'($urandom);
            exp_q.push_back({16'h20FF + 16'(i), seq_wdata_in});
            wr(OFS_MICRO_PORT, seq_wdata_in);
            drain("micro_byte");
        end
        cmp({22'h0, chan_en_out[1], int_mem_out}, 24'h00_0001);
        rd(OFS_STATUS, 8'h08);
        drain("micro_write");
        // channel 1 from ram to the micro read port, one byte
        prog(1, 16'h0040, 16'h0001);
        wr(OFS_CTRL0 + 8'h01, 8'h01);
        repeat (12) @(negedge mclk_in);
        rd(OFS_STATUS, 8'h10);
        rd(OFS_MICRO_PORT, 8'h1A);
        drain("micro_read");
        // back-to-back records: count reloads, channel stays up
        prog(0, 16'h5000, 16'h0002);
        wr(OFS_CTRL0, 8'h17); // firmware sets enable, reload, always
        seq_send(16'h5000, 4);
        drain("records");
        cmp({22'h0, chan_en_out[0], int_mem_out}, 24'h00_0002);
        rd(OFS_CNT_LO, 8'h02);
        // abort mid-block: no more cycles, count stays where it stopped
        prog(0, 16'h4000, 16'h0005);
        wr(OFS_CTRL0, 8'h03);
        seq_send(16'h4000, 2);
        drain("abort_prep");
        wr(OFS_CTRL0, 8'h00);
        seq_wvalid_in = 1'b1;
        hits = 0;
        repeat (20) @(negedge mclk_in) hits += int'(seq_wready_out | mem_req_out);
        seq_wvalid_in = 1'b0;
        cmp(24'(hits), 24'h00_0000);
        cmp({22'h0, chan_en_out[0], int_mem_out}, 24'h00_0000);
        rd(OFS_CNT_LO, 8'h03);
        drain("abort");
        give_verdict();
    end
endmodule
`default_nettype wire
